// File: verilog/boot_mode_select.sv
/*
  operating-mode selection, boot rom visibility, vector remap, security
  and first-character baud detection, with an axi4-lite register slave.
  assumes mode and rx pins are asynchronous and reset is held >= 4 edges.
*/
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module boot_mode_select #(
  parameter int SLOW_BIT_CYC = boot_mode_pkg::CLK_HZ / boot_mode_pkg::BAUD_SLOW
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        mode_pin_a,
  input  wire logic        mode_pin_b,
  input  wire logic        security_disable_bit,
  input  wire logic        mem_erased,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_vec_fetch,
  output logic [15:0]      mapped_addr,
  output logic             rom_sel,
  output logic [7:0]       rom_data,
  input  wire logic        rx_pin,
  output logic [7:0]       rx_byte,
  output logic             rx_valid,
  output logic [3:0]       op_mode,
  output logic             security_active
);

  localparam logic [15:0] SLOW_LEN = SLOW_BIT_CYC[15:0];

  // ----------------------------------------------------------------
  // pin synchronisers and agreement filter
  // ----------------------------------------------------------------
  logic [2:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;
  logic       pin_a_f, pin_b_f, rx_f;

  // three stages, no reset so values are valid at release
  always_ff @(posedge aclk) begin
    sync1_ff <= {rx_pin, mode_pin_b, mode_pin_a};
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
    for (int i = 0; i < 3; i++) begin
      if (sync2_ff[i] == sync3_ff[i]) begin
        filt_ff[i] <= sync3_ff[i];
      end
    end
  end
  assign pin_a_f = filt_ff[0];
  assign pin_b_f = filt_ff[1];
  assign rx_f    = filt_ff[2];

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic        aw_full_ff, w_full_ff, w_lane0_ff, bvalid_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic        do_wr, wr_mode, wr_status, wr_sec, wr_rom, wr_hit;

  // word offset into the rom image window, or all ones
  function automatic logic [7:0] rom_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - boot_mode_pkg::OFS_ROM;
    if (a >= boot_mode_pkg::OFS_ROM && 32'(d[11:2]) < boot_mode_pkg::ROM_BYTES) begin
      rom_index = d[9:2];
    end else begin
      rom_index = 8'hff;
    end
  endfunction : rom_index

  assign awready = !aw_full_ff;
  assign wready  = !w_full_ff;
  assign arready = !rvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = rdata_ff;
  assign do_wr   = aw_full_ff && w_full_ff && !bvalid_ff;

  // write address decode
  always_comb begin
    wr_mode   = 1'b0;
    wr_status = 1'b0;
    wr_sec    = 1'b0;
    wr_rom    = 1'b0;
    if (aw_addr_ff == boot_mode_pkg::OFS_MODE) begin
      wr_mode = do_wr && w_lane0_ff;
    end else if (aw_addr_ff == boot_mode_pkg::OFS_STATUS) begin
      wr_status = do_wr && w_lane0_ff;
    end else if (aw_addr_ff == boot_mode_pkg::OFS_SEC) begin
      wr_sec = do_wr && w_lane0_ff;
    end else if (rom_index(aw_addr_ff) != 8'hff) begin
      wr_rom = do_wr && w_lane0_ff;
    end
  end
  assign wr_hit = (aw_addr_ff == boot_mode_pkg::OFS_MODE) ||
                  (aw_addr_ff == boot_mode_pkg::OFS_STATUS) ||
                  (aw_addr_ff == boot_mode_pkg::OFS_SEC) ||
                  (rom_index(aw_addr_ff) != 8'hff);

  // write channels held until both present, then one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff  <= boot_mode_pkg::DATA_ZERO;
      w_lane0_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= boot_mode_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= {awaddr[11:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_full_ff  <= 1'b1;
        w_data_ff  <= wdata;
        w_lane0_ff <= wstrb[0];
      end
      if (do_wr) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? boot_mode_pkg::RESP_OKAY : boot_mode_pkg::RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  boot_mode_pkg::mode_bits_t mode_ff;
  boot_mode_pkg::op_mode_t   cur_mode;
  logic                      in_reset_ff, capture;

  assign capture  = in_reset_ff && aresetn;
  assign cur_mode = boot_mode_pkg::decode_mode(mode_ff); // [R3]

  // marks the first edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_reset_ff <= 1'b1;
    end else begin
      in_reset_ff <= 1'b0;
    end
  end

  // pin capture at release, privileged software writes after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= boot_mode_pkg::MODE_RESET;
    end else if (capture) begin // [R16]
      mode_ff.expanded <= pin_a_f && security_disable_bit; // [R1] [R10]
      mode_ff.special  <= !pin_b_f; // [R2]
      mode_ff.rom_vis  <= !pin_b_f && !(pin_a_f && security_disable_bit); // [R4]
    end else if (wr_mode && mode_ff.special) begin // [R9]
      mode_ff.expanded <= w_data_ff[boot_mode_pkg::BIT_EXPANDED];
      mode_ff.special  <= w_data_ff[boot_mode_pkg::BIT_SPECIAL];
      // cleared whenever the result is a normal mode
      mode_ff.rom_vis  <= w_data_ff[boot_mode_pkg::BIT_ROM_VIS] &&
                          w_data_ff[boot_mode_pkg::BIT_SPECIAL]; // [R5]
    end
  end

  // ----------------------------------------------------------------
  // security unlock
  // ----------------------------------------------------------------
  logic unlocked_ff, sec_act_ff;

  // unlock only from bootstrap once memories are erased
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlocked_ff <= 1'b0;
      sec_act_ff  <= 1'b0;
    end else begin
      if (wr_sec && w_data_ff[boot_mode_pkg::BIT_UNLOCK] &&
          cur_mode == boot_mode_pkg::MODE_BOOT && mem_erased) begin
        unlocked_ff <= 1'b1; // [R11]
      end
      sec_act_ff <= !security_disable_bit && !unlocked_ff;
    end
  end
  assign security_active = sec_act_ff;
  assign op_mode         = cur_mode;

  // ----------------------------------------------------------------
  // vector remap and boot rom decode
  // ----------------------------------------------------------------
  logic [15:0] eff_addr, rom_off;
  logic        rom_hit;
  logic [15:0] mapped_ff;
  logic        rom_sel_ff;

  always_comb begin
    eff_addr = cpu_addr;
    if (cpu_vec_fetch && mode_ff.special) begin
      eff_addr[boot_mode_pkg::BIT_A14] = 1'b0; // [R8]
    end
  end
  assign rom_hit = mode_ff.rom_vis && eff_addr >= boot_mode_pkg::ROM_BASE &&
                   eff_addr <= boot_mode_pkg::ROM_LAST; // [R6]
  assign rom_off = eff_addr - boot_mode_pkg::ROM_BASE;

  // address out and rom select line up with rom read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mapped_ff  <= 16'h0000;
      rom_sel_ff <= 1'b0;
    end else begin
      mapped_ff  <= eff_addr;
      rom_sel_ff <= rom_hit;
    end
  end
  assign mapped_addr = mapped_ff;
  assign rom_sel     = rom_sel_ff;

  boot_rom_mem u_rom (
    .aclk    (aclk),
    .wr_en   (wr_rom && mode_ff.special),
    .wr_addr (rom_index(aw_addr_ff)),
    .wr_data (w_data_ff[7:0]),
    .rd_addr (rom_off[7:0]),
    .rd_data (rom_data)
  );

  // ----------------------------------------------------------------
  // serial receiver with first-character baud detection
  // ----------------------------------------------------------------
  boot_mode_pkg::rx_state_t rx_st_ff;
  logic [15:0] cnt_ff, bit_len;
  logic [7:0]  shift_ff, rx_byte_ff;
  logic [2:0]  nbits_ff;
  logic        rx_prev_ff, rx_valid_ff, alt_ff, first_ff, frame_ff, tick, stop_ok;

  assign bit_len = alt_ff ? SLOW_LEN : boot_mode_pkg::FAST_LEN; // [R12]
  assign tick    = cnt_ff == 16'h0000;
  assign stop_ok = rx_st_ff == boot_mode_pkg::RX_STOP && tick && rx_f;

  // bit sampler: falling edge, centre of start, data, stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_ff   <= boot_mode_pkg::RX_IDLE;
      cnt_ff     <= 16'h0000;
      shift_ff   <= 8'h00;
      nbits_ff   <= 3'h0;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_f;
      if (!tick) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
      case (rx_st_ff)
        boot_mode_pkg::RX_IDLE: begin
          if (rx_prev_ff && !rx_f) begin // [R14]
            rx_st_ff <= boot_mode_pkg::RX_START;
            cnt_ff   <= (bit_len >> 1) - 16'h0001;
          end
        end
        boot_mode_pkg::RX_START: begin
          if (tick) begin
            rx_st_ff <= rx_f ? boot_mode_pkg::RX_IDLE : boot_mode_pkg::RX_DATA; // [R14]
            cnt_ff   <= bit_len - 16'h0001;
            nbits_ff <= 3'h0;
          end
        end
        boot_mode_pkg::RX_DATA: begin
          if (tick) begin
            shift_ff <= {rx_f, shift_ff[7:1]};
            nbits_ff <= nbits_ff + 3'h1;
            cnt_ff   <= bit_len - 16'h0001;
            if (nbits_ff == 3'h7) begin
              rx_st_ff <= boot_mode_pkg::RX_STOP;
            end
          end
        end
        default: begin
          if (tick) begin
            rx_st_ff <= boot_mode_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // byte delivery, first-character rate choice, framing flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      alt_ff      <= 1'b0;
      first_ff    <= 1'b0;
      frame_ff    <= 1'b0;
    end else begin
      rx_valid_ff <= stop_ok; // [R14]
      if (stop_ok) begin
        rx_byte_ff <= shift_ff;
        first_ff   <= 1'b1;
        if (!first_ff && (shift_ff == boot_mode_pkg::ALT_CHAR_A ||
                          shift_ff == boot_mode_pkg::ALT_CHAR_B)) begin
          alt_ff <= 1'b1; // [R15] [R13]
        end
      end
      // a new framing error wins over a software clear
      if (rx_st_ff == boot_mode_pkg::RX_STOP && tick && !rx_f) begin
        frame_ff <= 1'b1; // [R14]
      end else if (wr_status && w_data_ff[boot_mode_pkg::BIT_FRAME]) begin
        frame_ff <= 1'b0;
      end
    end
  end
  assign rx_byte  = rx_byte_ff;
  assign rx_valid = rx_valid_ff;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= boot_mode_pkg::DATA_ZERO;
      rresp_ff  <= boot_mode_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= boot_mode_pkg::RESP_OKAY;
      rdata_ff  <= boot_mode_pkg::DATA_ZERO;
      if ({araddr[11:2], 2'b00} == boot_mode_pkg::OFS_MODE) begin
        rdata_ff <= {29'h0, mode_ff};
      end else if ({araddr[11:2], 2'b00} == boot_mode_pkg::OFS_STATUS) begin
        rdata_ff <= {16'h0, rx_byte_ff, frame_ff, first_ff, alt_ff, sec_act_ff, cur_mode};
      end else if ({araddr[11:2], 2'b00} == boot_mode_pkg::OFS_SEC) begin
        rdata_ff <= {31'h0, unlocked_ff};
      end else begin
        rresp_ff <= boot_mode_pkg::RESP_SLVERR;
      end
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start_ok;
    rx_st_ff == boot_mode_pkg::RX_START && tick && !rx_f;
  endsequence
  sequence s_first_alt;
    stop_ok && !first_ff && shift_ff == boot_mode_pkg::ALT_CHAR_A;
  endsequence

  chk_pin_a_cap: assert property (capture |=> mode_ff.expanded == // [R1]
    ($past(pin_a_f) && $past(security_disable_bit))) else $error("pin a capture wrong");
  chk_pin_b_cap: assert property (capture |=> mode_ff.special == !$past(pin_b_f)) // [R2]
    else $error("pin b capture wrong");
  chk_rom_vis_reset: assert property (capture |=> // [R4]
    mode_ff.rom_vis == (cur_mode == boot_mode_pkg::MODE_BOOT)) else $error("rom vis reset");
  chk_normal_rom_off: assert property (!mode_ff.special |-> !mode_ff.rom_vis) // [R5]
    else $error("rom visible in normal mode");
  chk_mode_lock: assert property (!mode_ff.special && !capture |=> $stable(mode_ff)) // [R9]
    else $error("mode changed in normal mode");
  chk_secure_pin_a: assert property (capture && !security_disable_bit |=> // [R10]
    !mode_ff.expanded) else $error("secured part took pin a");
  chk_rom_decode: assert property (!mode_ff.rom_vis |=> !rom_sel) // [R6]
    else $error("rom selected while hidden");
  chk_vec_a14: assert property (cpu_vec_fetch && mode_ff.special |=> // [R8]
    !mapped_addr[boot_mode_pkg::BIT_A14]) else $error("a14 not forced");
  chk_unlock_gate: assert property ($rose(unlocked_ff) |-> $past(mem_erased) && // [R11]
    $past(cur_mode) == boot_mode_pkg::MODE_BOOT) else $error("bad unlock");
  chk_start_data: assert property (s_start_ok |=> rx_st_ff == boot_mode_pkg::RX_DATA && // [R14]
    cnt_ff == bit_len - 16'h0001) else $error("start bit not confirmed");
  chk_alt_baud: assert property (s_first_alt |=> alt_ff ##1 alt_ff) // [R15]
    else $error("alt rate not chosen");

endmodule : boot_mode_select

// File: verilog/boot_mode_pkg.sv
/*
  constants, types and decode helpers for the operating-mode and boot-rom
  control block.
  assumes a single 25 MHz clock and an axi4-lite register bus.
*/
// Notes on behaviour
// R1 - pin a at reset release sets expanded bit
// R2 - inverted pin b at release sets special bit
// R3 - two bits decode four operating modes
// R4 - boot rom visible at reset only in bootstrap
// R5 - rom-visible writable only in special modes
// R6 - boot rom decoded only while visible bit set
// R7 - boot rom holds 192 bytes
// R8 - special mode forces a14 low on vectors
// R9 - mode bits writable only in special mode
// R10 - secured part ignores pin a at reset
// R11 - security unlock only in bootstrap after erase
// R12 - serial rates 7812 and 1200 baud
// R13 - host sends all-ones first character
// R14 - start edge, centre samples, stop framing check
// R15 - first char c0 or e0 selects 1200 baud
// R16 - mode captured at release, stable until write
package boot_mode_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MODE   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_SEC    = 12'h008;
  localparam logic [11:0] OFS_ROM    = 12'h100;

  // field positions
  localparam int BIT_EXPANDED = 0;
  localparam int BIT_SPECIAL  = 1;
  localparam int BIT_ROM_VIS  = 2;
  localparam int BIT_UNLOCK   = 0;
  localparam int BIT_SEC_ACT  = 4;
  localparam int BIT_ALT_BAUD = 5;
  localparam int BIT_FIRST    = 6;
  localparam int BIT_FRAME    = 7;
  localparam int BIT_A14      = 14;

  // reset values
  localparam logic [2:0]  MODE_RESET = 3'h0;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

  // boot rom placement
  localparam int          ROM_BYTES = 192;
  localparam logic [15:0] ROM_BASE  = 16'hbf40;
  localparam logic [15:0] ROM_LAST  = 16'hbfff;

  // serial timing
  localparam int          CLK_HZ    = 25_000_000;
  localparam int          BAUD_FAST = 7812;
  localparam int          BAUD_SLOW = 1200;
  localparam logic [15:0] FAST_LEN  = 16'(CLK_HZ / BAUD_FAST);
  localparam logic [7:0]  ALT_CHAR_A = 8'hc0;
  localparam logic [7:0]  ALT_CHAR_B = 8'he0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_SINGLE   = 4'b0001,
    MODE_EXPANDED = 4'b0010,
    MODE_BOOT     = 4'b0100,
    MODE_TEST     = 4'b1000
  } op_mode_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  typedef struct packed {
    logic rom_vis;
    logic special;
    logic expanded;
  } mode_bits_t;

  // select bits to operating mode
  function automatic op_mode_t decode_mode(input mode_bits_t m);
    case ({m.special, m.expanded})
      2'b00:   decode_mode = MODE_SINGLE;
      2'b01:   decode_mode = MODE_EXPANDED;
      2'b10:   decode_mode = MODE_BOOT;
      default: decode_mode = MODE_TEST;
    endcase
  endfunction : decode_mode

endpackage : boot_mode_pkg

// File: verilog/boot_rom_mem.sv
/*
  boot rom image store: one write port, one registered read port.
  assumes writes come only from privileged software in special modes.
*/
`timescale 1ns/1ps
module boot_rom_mem (
  input  wire logic       aclk,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [boot_mode_pkg::ROM_BYTES]; // [R7]

  // image write, out-of-range writes dropped
  always_ff @(posedge aclk) begin
    if (wr_en && (32'(wr_addr) < boot_mode_pkg::ROM_BYTES)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, out of range reads zero
  always_ff @(posedge aclk) begin
    if (32'(rd_addr) < boot_mode_pkg::ROM_BYTES) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : boot_rom_mem

// File: testbench/board_host_model.sv
/*
  board mode straps, security fuse, erase flag and serial host.
  assumes the bench calls its tasks; all pins move on aclk rising edges.
*/
`timescale 1ns/1ps
module board_host_model (
  input  wire logic aclk,
  output logic      mode_pin_a,
  output logic      mode_pin_b,
  output logic      security_disable_bit,
  output logic      mem_erased,
  output logic      rx_pin
);
  // quiet board, serial line idles high
  initial begin
    mode_pin_a           = 1'b0;
    mode_pin_b           = 1'b1;
    security_disable_bit = 1'b1;
    mem_erased           = 1'b0;
    rx_pin               = 1'b1;
  end

  // straps, then time for the pin filter to settle
  task automatic set_pins(input logic sec, input logic pb, input logic pa);
    @(posedge aclk);
    security_disable_bit <= sec;
    mode_pin_b           <= pb;
    mode_pin_a           <= pa;
    repeat (6) @(posedge aclk);
  endtask : set_pins

  task automatic set_erased(input logic e);
    @(posedge aclk);
    mem_erased <= e;
  endtask : set_erased

  // start, eight bits lsb first, stop level from caller, then idle
  task automatic send_char(input logic [7:0] ch, input int len, input logic stp);
    logic [9:0] f;
    f = {stp, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rx_pin <= f[i];
      repeat (len - 1) @(posedge aclk);
    end
    @(posedge aclk);
    rx_pin <= 1'b1; // back to idle high
    repeat (len) @(posedge aclk);
  endtask : send_char
endmodule : board_host_model

// File: testbench/tb.sv
/*
  self-checking bench for the mode select block.
  assumes the board model drives pins and straps; bus master lives here.
*/
`timescale 1ns/1ps
module tb;
  localparam int SLOW = 64;
  localparam int FAST = int'(boot_mode_pkg::FAST_LEN);
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, mode_pin_a, mode_pin_b, mem_erased;
  logic        security_disable_bit, cpu_vec_fetch, rom_sel, rx_pin, rx_valid;
  logic        security_active;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb, op_mode;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] cpu_addr, mapped_addr;
  logic [7:0]  rom_data, rx_byte;
  int          miscompares, compares;
  int          nvalid = 0;

  boot_mode_select #(.SLOW_BIT_CYC(SLOW)) dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .mode_pin_a, .mode_pin_b,
    .security_disable_bit, .mem_erased, .cpu_addr, .cpu_vec_fetch, .mapped_addr,
    .rom_sel, .rom_data, .rx_pin, .rx_byte, .rx_valid, .op_mode, .security_active);
  board_host_model model (.aclk, .mode_pin_a, .mode_pin_b, .security_disable_bit,
    .mem_erased, .rx_pin);

  // clock and received-byte pulse count
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (rx_valid === 1'b1) nvalid <= nvalid + 1;

  // ----------------------------------------------------------------
  // report and compare
  // ----------------------------------------------------------------
  task automatic results;
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // axi4-lite master, bounded waits
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta   = awvalid & awready;
      tw   = wvalid & wready;
      tk   = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) begin
        bready <= 1'b0;
        return;
      end
    end
    miscompares++;
    results();
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic ta, tk;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta   = arvalid & arready;
      tk   = rvalid;
      rv   = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tk) begin
        rready <= 1'b0;
        return;
      end
    end
    miscompares++;
    results();
  endtask : rd

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : rst

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] cs [6];
    logic       sp, ex;
    logic [2:0] m;
    logic [3:0] oh;
    logic [7:0] ch;
    cs = '{3'h5, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1}; // {fuse, pin b, pin a}
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_vec_fetch} = 7'h0;
    {awaddr, araddr, wdata, cpu_addr} = 72'h0;
    wstrb = 4'hf;
    {miscompares, compares} = 64'h0;
    repeat (2) @(posedge aclk);
    // all four open strap combinations and two secured ones
    for (int i = 0; i < 6; i++) begin
      model.set_pins(cs[i][2], cs[i][1], cs[i][0]);
      rst();
      model.set_pins(cs[i][2], ~cs[i][1], ~cs[i][0]); // pins move after capture
      sp = ~cs[i][1];
      ex = cs[i][2] & cs[i][0];
      m  = {sp & ~ex, sp, ex};
      oh = 4'h1 << {sp, ex};
      rd(boot_mode_pkg::OFS_MODE);
      chk("mode", {29'h0, m}, rv);
      chk("op_mode", {28'h0, oh}, {28'h0, op_mode});
      rd(boot_mode_pkg::OFS_STATUS);
      chk("status", {27'h0, ~cs[i][2], oh}, {27'h0, rv[4:0]});
      chk("sec_out", {31'h0, ~cs[i][2]}, {31'h0, security_active});
      wr(12'h3f8, 32'h0000_00a5);
      @(posedge aclk);
      cpu_addr      <= 16'hfffe;
      cpu_vec_fetch <= 1'b1;
      @(posedge aclk);
      cpu_vec_fetch <= 1'b0;
      @(negedge aclk);
      chk("mapped", {16'h0, sp ? 16'hbffe : 16'hfffe}, {16'h0, mapped_addr});
      chk("rom_sel", {31'h0, m[2]}, {31'h0, rom_sel});
      if (m[2]) chk("rom_data", 32'h0000_00a5, {24'h0, rom_data});
      wr(boot_mode_pkg::OFS_MODE, 32'h0000_0007);
      chk("wr_resp", {30'h0, boot_mode_pkg::RESP_OKAY}, {30'h0, resp});
      rd(boot_mode_pkg::OFS_MODE);
      chk("mode_wr", sp ? 32'h0000_0007 : {29'h0, m}, rv);
    end
    // unlock of a secured part, only after erase
    wr(boot_mode_pkg::OFS_MODE, 32'h0000_0006);
    wr(boot_mode_pkg::OFS_SEC, 32'h0000_0001);
    rd(boot_mode_pkg::OFS_STATUS);
    chk("sec_kept", 32'h1, {31'h0, rv[4]});
    model.set_erased(1'b1);
    wr(boot_mode_pkg::OFS_SEC, 32'h0000_0001);
    rd(boot_mode_pkg::OFS_STATUS);
    chk("sec_off", 32'h0, {31'h0, rv[4]});
    rd(12'h00c);
    chk("unmapped", {30'h0, boot_mode_pkg::RESP_SLVERR}, {30'h0, resp});
    rd(boot_mode_pkg::OFS_ROM);
    chk("rom_rd", {30'h0, boot_mode_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(12'h00c, 32'h0000_0001);
    chk("unmapped_wr", {30'h0, boot_mode_pkg::RESP_SLVERR}, {30'h0, resp});
    // first character at the fast rate picks the rate
    for (int i = 0; i < 2; i++) begin
      ch = (i == 0) ? 8'hff : 8'hc0;
      model.set_pins(1'b1, 1'b0, 1'b0);
      rst();
      model.send_char(ch, FAST, 1'b1);
      rd(boot_mode_pkg::OFS_STATUS);
      chk("rx_status", {16'h0, ch, 1'b0, 1'b1, ~ch[5], 5'h0}, {16'h0, rv[15:5], 5'h0});
      chk("rx_count", 32'(i + 1), nvalid);
    end
    // slow rate in force, then a broken stop bit
    model.send_char(8'h5a, SLOW, 1'b1);
    chk("rx_byte", 32'h0000_005a, {24'h0, rx_byte});
    model.send_char(8'h33, SLOW, 1'b0);
    rd(boot_mode_pkg::OFS_STATUS);
    chk("frame", 32'h0000_00b5, {23'h0, rv[15:7]});
    chk("rx_count2", 32'h3, nvalid);
    wr(boot_mode_pkg::OFS_STATUS, 32'h0000_0080);
    rd(boot_mode_pkg::OFS_STATUS);
    chk("frame_clr", 32'h0, {31'h0, rv[7]});
    results();
  end
endmodule : tb
